// ---- hdl/ref_ladder_dac_control.sv ----
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
module ref_ladder_dac_control #(
  parameter int LEVELS = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic [1:0] pinDigitalIn,
  input wire logic [1:0] pinDigitalOutReq,
  input wire logic [1:0] pinPullupReq,
  input wire logic [1:0] pinCurrentDriveReq,
  output logic [1:0] pinDigitalRead,
  output logic [1:0] pinDigitalOutEn,
  output logic [1:0] pinInputDetectEn,
  output logic [1:0] pinPullupEn,
  output logic [1:0] pinCurrentDriveEn,
  output logic [1:0] pinAnalogOut,
  output logic ladderEnable,
  output logic [LEVELS-1:0] tapSelect,
  output logic [1:0] positiveSourceSelect,
  output logic negativeSourceSelect,
  output logic compRefValid,
  output logic adcRefValid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] controlMain;
    logic [7:0] levelSelect;
    logic [7:0] readData;
  } state_t;

  state_t state;
  state_t next_state;

  logic converterEnable;
  logic [1:0] refPinEnable;

  // Sleep is not an input: the registers run on the system clock which
  // keeps running, and nothing but register writes and rst touches controlMain and levelSelect, so wake-up leaves
  // the control settings as they were.
  always_comb begin
    next_state = state;
    next_state.readData = 8'h00;
    if (wrStrobe && addr == ref_ladder_pkg::CONTROL_MAIN_ADDR) begin
      next_state.controlMain = wrData & ref_ladder_pkg::CONTROL_MAIN_MASK;
    end
    if (wrStrobe && addr == ref_ladder_pkg::LEVEL_SELECT_ADDR) begin
      next_state.levelSelect = wrData & ref_ladder_pkg::LEVEL_SELECT_MASK;
    end
    if (rdStrobe) begin
      unique case (addr)
        ref_ladder_pkg::CONTROL_MAIN_ADDR: begin
          next_state.readData = state.controlMain;
        end
        ref_ladder_pkg::LEVEL_SELECT_ADDR: begin
          next_state.readData = state.levelSelect;
        end
        default: begin
          next_state.readData = 8'h00;
        end
      endcase
    end
    if (rst) begin
      next_state.controlMain = ref_ladder_pkg::CONTROL_MAIN_RESET;
      next_state.levelSelect = ref_ladder_pkg::LEVEL_SELECT_RESET;
      next_state.readData = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------
  // Ladder control
  // ----------------------------------------------------------------
  assign converterEnable = state.controlMain[ref_ladder_pkg::ENABLE_POS];
  assign ladderEnable = converterEnable;
  assign positiveSourceSelect =
    state.controlMain[ref_ladder_pkg::PSS_LSB +: 2];
  assign negativeSourceSelect = state.controlMain[ref_ladder_pkg::NSS_POS];
  assign compRefValid = converterEnable;
  assign adcRefValid = converterEnable;

  ladder_tap_decode #(
    .LEVELS(LEVELS)
  ) u_decode (
    .enable(converterEnable),
    .levelCode(state.levelSelect[ref_ladder_pkg::LEVEL_W-1:0]),
    .tapSelect(tapSelect)
  );

  // ----------------------------------------------------------------
  // Pin override
  // ----------------------------------------------------------------
  assign refPinEnable = {state.controlMain[ref_ladder_pkg::PIN2_OE_POS],
                         state.controlMain[ref_ladder_pkg::PIN1_OE_POS]};

  // Index 0 is pin 1, index 1 is pin 2.
  assign pinAnalogOut = refPinEnable;
  assign pinDigitalOutEn = pinDigitalOutReq & ~refPinEnable;
  assign pinInputDetectEn = ~refPinEnable;
  assign pinPullupEn = pinPullupReq & ~refPinEnable;
  assign pinCurrentDriveEn = pinCurrentDriveReq & ~refPinEnable;
  assign pinDigitalRead = pinDigitalIn & ~refPinEnable;
  assign rdData = state.readData;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence levelWrite_s;
    wrStrobe && addr == ref_ladder_pkg::LEVEL_SELECT_ADDR;
  endsequence

  enable_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    wrStrobe && addr == 4'h0 |=> ladderEnable == $past(wrData[7]))
    else $error("Ladder enable does not follow the written bit 7.");

  level_tap_a: assert property (@(posedge ref_clk) disable iff (rst)
    levelWrite_s ##1 ladderEnable |-> tapSelect[$past(wrData[4:0])])
    else $error("Tap does not follow written level code.");

  tap_onehot_a: assert property (@(posedge ref_clk) disable iff (rst)
    ladderEnable ? $onehot(tapSelect) : tapSelect == '0)
    else $error("Tap selection is not one-hot.");

  source_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    wrStrobe && addr == 4'h0 |=> positiveSourceSelect == $past(wrData[3:2]))
    else $error("Positive source select not written.");

  route_ref_a: assert property (@(posedge ref_clk) disable iff (rst)
    compRefValid == ladderEnable && adcRefValid == ladderEnable)
    else $error("Reference routing disagrees with enable.");

  pin_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    wrStrobe && addr == 4'h0 |=> pinAnalogOut == $past({wrData[4], wrData[5]}))
    else $error("Pin reference drive not written.");

  pin_override_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pinAnalogOut & (pinDigitalOutEn | pinPullupEn | pinInputDetectEn
      | pinCurrentDriveEn)) == 2'h0)
    else $error("Reference pin keeps a digital function.");

  pin_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pinAnalogOut & pinDigitalRead) == 2'h0)
    else $error("Reference pin reads nonzero.");

  reset_clear_a: assert property (@(posedge ref_clk)
    rst |=> !ladderEnable && pinAnalogOut == 2'h0 && state.levelSelect == 8'h00)
    else $error("Reset did not clear the converter.");

  unimpl_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    rdStrobe && addr == 4'h1 |=> rdData[7:5] == 3'h0)
    else $error("Unimplemented level bits read nonzero.");

  keep_main_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(wrStrobe && addr == 4'h0) |=> $stable(state.controlMain))
    else $error("Control register changed without a write.");

endmodule : ref_ladder_dac_control

// ---- common/ref_ladder_pkg.sv ----
// What this block does
// - Enable bit 7 activates the converter.
// - Level code bits 4:0 pick 32 levels.
// - Output equals negative plus span times code/32.
// - Positive source: pin, supply or fixed reference.
// - Output routes to comparator, analog channel, pins.
// - Pin enables bits 5,4 drive reference out.
// - Reference pin overrides buffer, detector, pull-up, drive.
// - Digital read of reference pin returns zero.
// - Keeps working in sleep; wake keeps settings.
// - Any reset disables, removes output, clears code.
// - Unimplemented bits read as zero.
package ref_ladder_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CONTROL_MAIN_ADDR = 4'h0;
  localparam logic [3:0] LEVEL_SELECT_ADDR = 4'h1;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int ENABLE_POS = 7;
  localparam int PIN1_OE_POS = 5;
  localparam int PIN2_OE_POS = 4;
  localparam int PSS_LSB = 2;
  localparam int NSS_POS = 0;
  localparam int LEVEL_W = 5;
  localparam logic [7:0] CONTROL_MAIN_MASK = 8'hBD;
  localparam logic [7:0] LEVEL_SELECT_MASK = 8'h1F;
  localparam logic [7:0] CONTROL_MAIN_RESET = 8'h00;
  localparam logic [7:0] LEVEL_SELECT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Positive source encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_SUPPLY = 2'h0,
    SRC_EXT_REF = 2'h1,
    SRC_FIXED_REF = 2'h2,
    SRC_RESERVED = 2'h3
  } pos_source_t;

endpackage : ref_ladder_pkg

// ---- hdl/ladder_tap_decode.sv ----
`timescale 1ns/10ps
// One-hot tap select across the ladder, gated by the enable bit.
module ladder_tap_decode #(
  parameter int LEVELS = 32
) (
  input wire logic enable,
  input wire logic [4:0] levelCode,
  output logic [LEVELS-1:0] tapSelect
);

  genvar i;
  generate
    for (i = 0; i < LEVELS; i++) begin : g_tap
      // Tap i sits at i/32 of the span above the negative end.
      assign tapSelect[i] = enable && (levelCode == 5'(i));
    end
  endgenerate

endmodule : ladder_tap_decode

// ---- verification/ladder_pad_model.sv ----
`timescale 1ns/10ps
// Pads show their outside level; the ladder reports the closed tap.
module ladder_pad_model (
  input wire logic [31:0] tapSelect,
  input wire logic [1:0] padLevel,
  output logic [1:0] pinDigitalIn,
  output logic [4:0] tapIndex
);
  always_comb begin
    pinDigitalIn = padLevel;
    tapIndex = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (tapSelect[i]) begin
        tapIndex = 5'(i);
      end
    end
  end
endmodule : ladder_pad_model

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic ref_clk, rst, wrStrobe, rdStrobe, ladderEnable, nss, cmpV, adcV;
  logic [3:0] addr;
  logic [7:0] wrData, rdData, v;
  logic [1:0] req, pad, din, dRead, outEn, detEn, puEn, drvEn, aOut, pss;
  logic [31:0] tapSelect;
  logic [4:0] tapIndex;
  int errCount, nChecks;
  ref_ladder_dac_control #(.LEVELS(32)) dut (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .pinDigitalIn(din), .pinDigitalOutReq(req),
    .pinPullupReq(req), .pinCurrentDriveReq(req), .pinDigitalRead(dRead),
    .pinDigitalOutEn(outEn), .pinInputDetectEn(detEn), .pinPullupEn(puEn),
    .pinCurrentDriveEn(drvEn), .pinAnalogOut(aOut),
    .ladderEnable(ladderEnable), .tapSelect(tapSelect),
    .positiveSourceSelect(pss), .negativeSourceSelect(nss),
    .compRefValid(cmpV), .adcRefValid(adcV));
  ladder_pad_model model (.tapSelect(tapSelect), .padLevel(pad),
    .pinDigitalIn(din), .tapIndex(tapIndex));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      errCount++;
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask : rd
  task test_control();
    rd(4'h0, v);
    chk("main", 8'h00, v);
    chk("detect", 2'h3, detEn);
    wr(4'h0, 8'hFF);
    rd(4'h0, v);
    chk("main", 8'hBD, v);
    chk("enable", 1'b1, ladderEnable);
    chk("refValid", 2'h3, {cmpV, adcV});
    chk("aout", 2'h3, aOut);
    chk("overrides", 8'h00, {outEn, puEn, drvEn, detEn});
    chk("read", 2'h0, dRead);
    chk("nss", 1'b1, nss);
    wr(4'h0, 8'hA0);
    chk("aout1", 2'h1, aOut);
    chk("outEn", 2'h2, outEn);
    chk("read1", 2'h2, dRead);
    for (int s = 0; s < 3; s++) begin
      wr(4'h0, 8'h80 | 8'(s << 2));
      chk("pss", 32'(s), pss);
    end
    $display("test_control done");
  endtask : test_control
  task test_levels();
    for (int c = 0; c < 32; c++) begin
      wr(4'h1, 8'(c));
      chk("tap", 32'h1 << c, tapSelect);
      chk("index", 32'(c), tapIndex);
    end
    wr(4'h1, 8'hFF);
    rd(4'h1, v);
    chk("level", 8'h1F, v);
    wr(4'h0, 8'h00);
    chk("tapOff", 32'h0, tapSelect);
    $display("test_levels done");
  endtask : test_levels
  task test_reset();
    wr(4'h2, 8'hFF);
    rd(4'h2, v);
    chk("unmapped", 8'h00, v);
    wr(4'h0, 8'hFF);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(4'h1, v);
    chk("levelRst", 8'h00, v);
    chk("aoutRst", 2'h0, aOut);
    chk("enRst", 1'b0, ladderEnable);
    @(posedge ref_clk);
    #1;
    chk("rdIdle", 8'h00, rdData);
    $display("test_reset done");
  endtask : test_reset
  task finish_test();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    rst = 1'b1;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    addr = 4'h0;
    wrData = 8'h00;
    req = 2'h3;
    pad = 2'h3;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    test_control();
    test_levels();
    test_reset();
    finish_test();
  end
  initial begin
    #200000;
    errCount++;
    finish_test();
  end
endmodule : tb_top
